/* rtl/saa_defs.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the supervision alarm aggregator.
// Assumes: Included by its bare name; definitions only.
// Notes: All delays are counted in ticks of one millisecond.
`ifndef SAA_DEFS_SVH
`define SAA_DEFS_SVH

// ****************************************************************************
// Clock and tick
// ****************************************************************************
`define SAA_CLK_MHZ 200
`define SAA_TICK_US 1000
`define SAA_TICK_CYC (`SAA_TICK_US * `SAA_CLK_MHZ)

// ****************************************************************************
// Pick-up and drop-off delays in milliseconds
// ****************************************************************************
`define SAA_TSYNC_PU_MS 17'd60000
`define SAA_TSYNC_DO_MS 17'd0
`define SAA_SUPPLY_PU_MS 17'd10000
`define SAA_SUPPLY_DO_MS 17'd10000
`define SAA_CT_PU_MS 17'd10000
`define SAA_CT_DO_MS 17'd10000
`define SAA_ROV_PU_MS 17'd10000
`define SAA_ROV_DO_MS 17'd1000
`define SAA_UV_PU_MS 17'd10000
`define SAA_UV_DO_MS 17'd1000
`define SAA_VT_PU_MS 17'd1250
`define SAA_VT_DO_MS 17'd10000

// ****************************************************************************
// Register offsets, fields and reset values
// ****************************************************************************
`define SAA_REG_STATUS 8'h00
`define SAA_REG_FAIL_SRC 8'h04
`define SAA_REG_ALM_SRC 8'h08
`define SAA_REG_POS_TIME 8'h0c
`define SAA_REG_FIB_TMO 8'h10
`define SAA_REG_EVENT 8'h14
`define SAA_POS_TIME_RST 32'h03e8_0014
`define SAA_FIB_TMO_RST 16'h000a
`define SAA_RATIO_FRAC 8
`define SAA_ST_FAIL 0
`define SAA_ST_ABN 1
`define SAA_ST_BLOCK 2
`define SAA_ST_HEALTHY 3
`define SAA_ST_ALARM 4
`endif

/* rtl/saa_pkg.sv */
// Purpose: Types shared by the supervision alarm aggregator.
// Assumes: Constants live in saa_defs.svh.
// Notes: Alarm indices give the bit order of the alarm source word.
package saa_pkg;
  typedef logic [16:0] saa_ms_t;
  typedef enum logic [3:0] {
    SAA_AL_TSYNC = 4'h0,
    SAA_AL_FSYNC = 4'h1,
    SAA_AL_OVR = 4'h2,
    SAA_AL_CRC = 4'h3,
    SAA_AL_SEQ = 4'h4,
    SAA_AL_TMO = 4'h5,
    SAA_AL_QUAL = 4'h6,
    SAA_AL_SUPPLY = 4'h7,
    SAA_AL_ROV = 4'h8,
    SAA_AL_VT = 4'h9,
    SAA_AL_UV = 4'ha,
    SAA_AL_CT = 4'hb,
    SAA_AL_SET = 4'hc
  } saa_alarm_e;
endpackage

/* rtl/saa_top.sv */
// Purpose: Self-supervision alarm aggregator with lamps, failure contact, blocking and event records.
// Assumes: Fault pins are asynchronous; measurement, settings and fibre inputs share core_clk_in.
// Notes: Registers are reached over AHB-Lite with zero wait states.
`timescale 1ns/1ps
`default_nettype none
`include "saa_defs.svh"
module saa_top #(
  parameter int N_SLOT = 4,
  parameter int N_POS = 4,
  parameter int TICK_CYC = `SAA_TICK_CYC
) (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [31:0] hrdata_out,
  input wire logic sample_error_in,
  input wire logic sample_overflow_in,
  input wire logic sample_buffer_error_in,
  input wire logic settings_error_in,
  input wire logic init_error_in,
  input wire logic logic_chip_fail_in,
  input wire logic self_check_error_in,
  input wire logic time_sync_fault_in,
  input wire logic input_supply_fault_in,
  input wire logic ct_fault_in,
  input wire logic vt_fault_in,
  input wire logic [N_SLOT-1:0] bo_hw_error_in,
  input wire logic [N_POS-1:0] pos_no_in,
  input wire logic [N_POS-1:0] pos_nc_in,
  input wire logic [15:0] residual_voltage_in,
  input wire logic [15:0] rov_ratio_in,
  input wire logic [15:0] phase_a_voltage_in,
  input wire logic [15:0] phase_b_voltage_in,
  input wire logic [15:0] phase_c_voltage_in,
  input wire logic [15:0] undervoltage_ratio_in,
  input wire logic [15:0] rated_secondary_voltage_in,
  input wire logic [1:0] measured_side_sel_in,
  input wire logic [1:0] sync_side_sel_in,
  input wire logic fib_frame_valid_in,
  input wire logic fib_crc_ok_in,
  input wire logic [15:0] fib_counter_in,
  input wire logic fib_quality_ok_in,
  input wire logic fib_overrun_in,
  input wire logic fib_sync_lost_in,
  output logic device_block_out,
  output logic [4:0] function_block_out,
  output logic healthy_lamp_out,
  output logic alarm_lamp_out,
  output logic failure_contact_out,
  output logic event_valid_out,
  output logic [7:0] event_code_out,
  output logic event_level_out
);
  localparam int FAIL_W = 7;
  localparam int ALM_W = 13 + N_SLOT + N_POS;
  localparam int EV_W = FAIL_W + ALM_W;
  localparam int DLY_N = 6 + N_POS;
  localparam int PIN_W = FAIL_W + 4 + N_SLOT + 2 * N_POS;

  logic [PIN_W-1:0] pin_meta_q, pin_sync_q;
  logic [FAIL_W-1:0] fail_src_q;
  logic [ALM_W-1:0] alm_src;
  logic fail_q, abn_q;
  logic [31:0] tick_cnt_q;
  logic tick_q;
  logic [DLY_N-1:0] dly_raw, dly_out;
  saa_pkg::saa_ms_t pu_lim [DLY_N];
  saa_pkg::saa_ms_t do_lim [DLY_N];
  logic rov_raw, uv_raw, set_alm_q;
  logic [31:0] rov_lim, uv_lim;
  logic [31:0] pos_time_q;
  logic [15:0] fib_tmo_q, fib_idle_q, fib_last_q;
  logic fib_have_q, fib_crc_q, fib_seq_q, fib_qual_q;
  logic [EV_W-1:0] ev_src, ev_prev_q, ev_pend_q, ev_grant;
  logic [7:0] ev_code;
  logic [31:0] ev_last_q;
  logic ap_valid_q, ap_write_q;
  logic [7:0] ap_addr_q;
  logic [31:0] rd_mux;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);

  // ****************************************************************************
  // Pin synchroniser
  // ****************************************************************************
  // Two stages on every fault pin; only the second stage feeds logic.
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end
    else
    begin
      pin_meta_q <= {pos_nc_in, pos_no_in, bo_hw_error_in, vt_fault_in, ct_fault_in, input_supply_fault_in,
                     time_sync_fault_in, self_check_error_in, logic_chip_fail_in, init_error_in,
                     settings_error_in, sample_buffer_error_in, sample_overflow_in, sample_error_in};
      pin_sync_q <= pin_meta_q;
    end
  end

  // ****************************************************************************
  // Failure class
  // ****************************************************************************
  // sampling path, settings, init, logic chip and self-check failures
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      fail_src_q <= '0;
    else
      fail_src_q <= pin_sync_q[FAIL_W-1:0];
  end

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      fail_q <= 1'b0;
      abn_q <= 1'b0;
    end
    else
    begin
      fail_q <= |fail_src_q;
      abn_q <= |alm_src;
    end
  end

  // ****************************************************************************
  // Millisecond tick
  // ****************************************************************************
  // A shared prescaler keeps each delay counter at 17 bits instead of 34.
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= (tick_cnt_q == 32'(TICK_CYC - 1));
      tick_cnt_q <= (tick_cnt_q == 32'(TICK_CYC - 1)) ? '0 : tick_cnt_q + 32'h0000_0001;
    end
  end

  // ****************************************************************************
  // Delayed alarm conditions
  // ****************************************************************************
  // residual voltage above ratio times rated secondary
  // any phase below ratio times rated secondary
  // Products are kept at full 32 bits so a large ratio cannot wrap the threshold.
  always_comb
  begin
    rov_lim = 32'(rov_ratio_in) * 32'(rated_secondary_voltage_in);
    uv_lim = 32'(undervoltage_ratio_in) * 32'(rated_secondary_voltage_in);
    rov_raw = ({8'h00, residual_voltage_in, 8'h00} > rov_lim);
    uv_raw = ({8'h00, phase_a_voltage_in, 8'h00} < uv_lim) ||
             ({8'h00, phase_b_voltage_in, 8'h00} < uv_lim) ||
             ({8'h00, phase_c_voltage_in, 8'h00} < uv_lim);
  end

  // Channel order: time sync, supply, CT, overvoltage, VT, undervoltage, then positions.
  always_comb
  begin
    dly_raw[5:0] = {uv_raw, pin_sync_q[10], rov_raw, pin_sync_q[9], pin_sync_q[8], pin_sync_q[7]};
    pu_lim[0] = `SAA_TSYNC_PU_MS;
    do_lim[0] = `SAA_TSYNC_DO_MS;
    pu_lim[1] = `SAA_SUPPLY_PU_MS;
    do_lim[1] = `SAA_SUPPLY_DO_MS;
    pu_lim[2] = `SAA_CT_PU_MS;
    do_lim[2] = `SAA_CT_DO_MS;
    pu_lim[3] = `SAA_ROV_PU_MS;
    do_lim[3] = `SAA_ROV_DO_MS;
    pu_lim[4] = `SAA_VT_PU_MS;
    do_lim[4] = `SAA_VT_DO_MS;
    pu_lim[5] = `SAA_UV_PU_MS;
    do_lim[5] = `SAA_UV_DO_MS;
    for (int p = 0; p < N_POS; p++)
    begin
      dly_raw[6+p] = (pin_sync_q[FAIL_W+4+N_SLOT+p] == pin_sync_q[FAIL_W+4+N_SLOT+N_POS+p]);
      pu_lim[6+p] = {1'b0, pos_time_q[15:0]} + {1'b0, pos_time_q[31:16]};
      do_lim[6+p] = {1'b0, pos_time_q[31:16]};
    end
  end

  // Each channel counts whole ticks while its input disagrees with its output.
  for (genvar i = 0; i < DLY_N; i++)
  begin : g_dly
    saa_pkg::saa_ms_t cnt_q;
    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
      if (!resetn_in)
      begin
        cnt_q <= '0;
        dly_out[i] <= 1'b0;
      end
      else if (dly_raw[i] == dly_out[i])
        cnt_q <= '0;
      else if (cnt_q >= (dly_raw[i] ? pu_lim[i] : do_lim[i]))
      begin
        dly_out[i] <= dly_raw[i];
        cnt_q <= '0;
      end
      else if (tick_q)
        cnt_q <= cnt_q + 17'h0_0001;
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      set_alm_q <= 1'b0;
    else
      set_alm_q <= (measured_side_sel_in == sync_side_sel_in);
  end

  // ****************************************************************************
  // Fibre sample receiver supervision
  // ****************************************************************************
  // Frame alarms stand until a frame arrives that no longer shows the fault.
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      fib_crc_q <= 1'b0;
      fib_seq_q <= 1'b0;
      fib_qual_q <= 1'b0;
      fib_have_q <= 1'b0;
      fib_last_q <= '0;
    end
    else if (fib_frame_valid_in)
    begin
      fib_crc_q <= !fib_crc_ok_in;
      if (fib_crc_ok_in)
      begin
        fib_seq_q <= fib_have_q && (fib_counter_in != fib_last_q + 16'h0001);
        fib_qual_q <= !fib_quality_ok_in;
        fib_last_q <= fib_counter_in;
        fib_have_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      fib_idle_q <= '0;
    else if (fib_frame_valid_in)
      fib_idle_q <= '0;
    else if (tick_q && fib_idle_q != 16'hffff)
      fib_idle_q <= fib_idle_q + 16'h0001;
  end

  // overrun and sync loss pass straight through
  // one alarm per output board slot
  always_comb
  begin
    alm_src = '0;
    alm_src[saa_pkg::SAA_AL_TSYNC] = dly_out[0];
    alm_src[saa_pkg::SAA_AL_FSYNC] = fib_sync_lost_in;
    alm_src[saa_pkg::SAA_AL_OVR] = fib_overrun_in;
    alm_src[saa_pkg::SAA_AL_CRC] = fib_crc_q;
    alm_src[saa_pkg::SAA_AL_SEQ] = fib_seq_q;
    alm_src[saa_pkg::SAA_AL_TMO] = (fib_idle_q >= fib_tmo_q);
    alm_src[saa_pkg::SAA_AL_QUAL] = fib_qual_q;
    alm_src[saa_pkg::SAA_AL_SUPPLY] = dly_out[1];
    alm_src[saa_pkg::SAA_AL_ROV] = dly_out[3];
    alm_src[saa_pkg::SAA_AL_VT] = dly_out[4];
    alm_src[saa_pkg::SAA_AL_UV] = dly_out[5];
    alm_src[saa_pkg::SAA_AL_CT] = dly_out[2];
    alm_src[saa_pkg::SAA_AL_SET] = set_alm_q;
    alm_src[13 +: N_SLOT] = pin_sync_q[FAIL_W+4 +: N_SLOT];
    alm_src[13+N_SLOT +: N_POS] = dly_out[DLY_N-1:6];
  end

  // ****************************************************************************
  // Lamps, contact and blocking
  // ****************************************************************************
  // failure blocks the device and swaps the lamps
  // alarm alone keeps healthy lamp lit
  assign device_block_out = fail_q;
  assign healthy_lamp_out = !fail_q;
  assign alarm_lamp_out = fail_q || abn_q;
  assign failure_contact_out = fail_q;

  // Groups: voltage, current, sampled values, outputs, position interlock.
  // minor alarms block only their group
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      function_block_out <= '0;
    else if (|fail_src_q)
      function_block_out <= 5'h1f;
    else
      function_block_out <= {|dly_out[DLY_N-1:6], |alm_src[13 +: N_SLOT], |alm_src[6:1],
                             dly_out[2], dly_out[3] | dly_out[4] | dly_out[5]};
  end

  // ****************************************************************************
  // Event records
  // ****************************************************************************
  // an edge of a source sets its pending bit, so further edges before it is sent merge into one record; records go out one per cycle
  always_comb
  begin
    ev_src = {alm_src, fail_src_q};
    ev_grant = '0;
    ev_code = '0;
    for (int e = EV_W - 1; e >= 0; e--)
    begin
      if (ev_pend_q[e])
      begin
        ev_grant = '0;
        ev_grant[e] = 1'b1;
        ev_code = 8'(e);
      end
    end
  end

  // A new edge wins over the grant that clears the same bit.
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      ev_prev_q <= '0;
      ev_pend_q <= '0;
      event_valid_out <= 1'b0;
      event_code_out <= '0;
      event_level_out <= 1'b0;
      ev_last_q <= '0;
    end
    else
    begin
      ev_prev_q <= ev_src;
      ev_pend_q <= (ev_pend_q & ~ev_grant) | (ev_src ^ ev_prev_q);
      event_valid_out <= |ev_pend_q;
      event_code_out <= ev_code;
      event_level_out <= |(ev_src & ev_grant);
      if (|ev_pend_q)
        ev_last_q <= {ev_last_q[31:16] + 16'h0001, 7'h00, |(ev_src & ev_grant), ev_code};
    end
  end

  // ****************************************************************************
  // AHB-Lite slave
  // ****************************************************************************
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;

  // Address phase is captured on any accepted NONSEQ or SEQ transfer.
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      ap_valid_q <= 1'b0;
      ap_write_q <= 1'b0;
      ap_addr_q <= '0;
    end
    else if (hready_in)
    begin
      ap_valid_q <= hsel_in && htrans_in[1];
      ap_write_q <= hwrite_in;
      ap_addr_q <= haddr_in[7:0];
    end
  end

  // Writable timing registers; unmapped writes are dropped.
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      pos_time_q <= `SAA_POS_TIME_RST;
      fib_tmo_q <= `SAA_FIB_TMO_RST;
    end
    else if (ap_valid_q && ap_write_q)
    begin
      if (ap_addr_q == `SAA_REG_POS_TIME)
        pos_time_q <= hwdata_in;
      if (ap_addr_q == `SAA_REG_FIB_TMO)
        fib_tmo_q <= hwdata_in[15:0];
    end
  end

  // Read data is registered at the address phase; unmapped reads give zero.
  always_comb
  begin
    case (haddr_in[7:0])
      `SAA_REG_STATUS: rd_mux = {27'h0, alarm_lamp_out, healthy_lamp_out, device_block_out, abn_q, fail_q};
      `SAA_REG_FAIL_SRC: rd_mux = 32'(fail_src_q);
      `SAA_REG_ALM_SRC: rd_mux = 32'(alm_src);
      `SAA_REG_POS_TIME: rd_mux = pos_time_q;
      `SAA_REG_FIB_TMO: rd_mux = {16'h0000, fib_tmo_q};
      `SAA_REG_EVENT: rd_mux = ev_last_q;
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      hrdata_out <= '0;
    else if (hready_in && hsel_in && htrans_in[1] && !hwrite_in)
      hrdata_out <= rd_mux;
  end

  // ****************************************************************************
  // Checks
  // ****************************************************************************
  sequence s_tsync_start;
    $rose(dly_raw[0]) && !dly_out[0];
  endsequence
  sequence s_tsync_quiet;
    !dly_out[0] [*8];
  endsequence

  a_fail_lamps: assert property (fail_q |-> device_block_out && !healthy_lamp_out && alarm_lamp_out)
    else $error("Failure did not block and swap lamps");
  a_fail_contact: assert property (fail_q |-> failure_contact_out)
    else $error("Failure contact not energised");
  a_subset_clear: assert property (!(|fail_src_q) && !(|alm_src) |=> function_block_out == 5'h00)
    else $error("Function group blocked without cause");
  a_fail_summary: assert property (fail_q == $past(|fail_src_q))
    else $error("Failure summary does not follow sources");
  a_alarm_only: assert property (abn_q && !fail_q |-> !device_block_out && healthy_lamp_out && alarm_lamp_out)
    else $error("Alarm alone changed blocking or healthy lamp");
  a_tsync_hold: assert property (s_tsync_start |=> s_tsync_quiet)
    else $error("Time sync alarm picked up too early");
  a_tsync_clear: assert property (!dly_raw[0] && dly_out[0] |=> !dly_out[0])
    else $error("Time sync alarm did not clear at once");
  a_setting_alarm: assert property ((measured_side_sel_in == sync_side_sel_in) |=> set_alm_q)
    else $error("Settings alarm missing");
  a_crc_alarm: assert property (fib_frame_valid_in && !fib_crc_ok_in |=> alm_src[saa_pkg::SAA_AL_CRC])
    else $error("Checksum alarm missing");
  a_seq_alarm: assert property (fib_frame_valid_in && fib_crc_ok_in && fib_have_q &&
                                fib_counter_in != fib_last_q + 16'h0001 |=> fib_seq_q)
    else $error("Sequence alarm missing");
  a_event_sent: assert property ((ev_src != ev_prev_q) |-> ##[1:40] event_valid_out)
    else $error("Source change produced no event");
endmodule
`default_nettype wire

/* verification/saa_centre_model.sv */
// Purpose: Control centre model that takes the block's event records.
// Assumes: One record for each cycle that event valid is high, sampled on the rising edge.
// Notes: Keeps a count and the last record for the bench to inspect.
`timescale 1ns/1ps
`default_nettype none
module saa_centre_model (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic ev_valid_in,
  input wire logic [7:0] ev_code_in,
  input wire logic ev_level_in,
  output logic [15:0] ev_count_out,
  output logic [7:0] ev_code_out,
  output logic ev_level_out
);
  // takes each record
  // The centre never stalls, so a record missed by the block is lost for good.
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      ev_count_out <= 16'h0000;
      ev_code_out <= 8'h00;
      ev_level_out <= 1'b0;
    end
    else if (ev_valid_in)
    begin
      ev_count_out <= ev_count_out + 16'h0001;
      ev_code_out <= ev_code_in;
      ev_level_out <= ev_level_in;
    end
  end
endmodule
`default_nettype wire

/* verification/saa_top_bench.sv */
// Purpose: Self-checking bench for the supervision alarm aggregator.
// Assumes: TICK_CYC is 1, so every delay is counted in single cycles.
// Notes: Bus reads check registers; lamps and blocking are checked at the pins.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module saa_top_bench;
  logic core_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic hsel = 1'b0, hwrite = 1'b0, tsf = 1'b0, sup = 1'b0, ctf = 1'b0, vtf = 1'b0;
  logic fv = 1'b0, fcrc = 1'b1, fq = 1'b1, fovr = 1'b0, fsl = 1'b0;
  logic [1:0] htrans = 2'h0, msel = 2'h0, ssel = 2'h1;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [6:0] fpin = 7'h00;
  logic [3:0] bo = 4'h0, pno = 4'hf, pnc = 4'h0;
  logic [15:0] resv = 16'h0000, phv = 16'h1000, fcnt = 16'h0000;
  wire hrdy, hresp, blk, hl, al, fc, evv, evl, ll;
  wire [31:0] hrd;
  wire [4:0] fb;
  wire [7:0] evc, lc;
  wire [15:0] cnt;
  int bad_count = 0;
  int num_checks = 0;
  int bits[5] = '{12, 2, 1, 13, 17};
  logic [4:0] fbx[5] = '{5'h00, 5'h04, 5'h04, 5'h08, 5'h10};
  saa_top #(.TICK_CYC(1)) saa_top_i (.core_clk_in(core_clk_in), .resetn_in(resetn_in), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hrdy), .hreadyout_out(hrdy), .hresp_out(hresp), .hrdata_out(hrd), .sample_error_in(fpin[0]),
    .sample_overflow_in(fpin[1]), .sample_buffer_error_in(fpin[2]), .settings_error_in(fpin[3]),
    .init_error_in(fpin[4]), .logic_chip_fail_in(fpin[5]), .self_check_error_in(fpin[6]),
    .time_sync_fault_in(tsf), .input_supply_fault_in(sup), .ct_fault_in(ctf), .vt_fault_in(vtf),
    .bo_hw_error_in(bo), .pos_no_in(pno), .pos_nc_in(pnc), .residual_voltage_in(resv), .rov_ratio_in(16'h0100),
    .phase_a_voltage_in(phv), .phase_b_voltage_in(phv), .phase_c_voltage_in(phv),
    .undervoltage_ratio_in(16'h0080), .rated_secondary_voltage_in(16'h0100), .measured_side_sel_in(msel),
    .sync_side_sel_in(ssel), .fib_frame_valid_in(fv), .fib_crc_ok_in(fcrc), .fib_counter_in(fcnt),
    .fib_quality_ok_in(fq), .fib_overrun_in(fovr), .fib_sync_lost_in(fsl), .device_block_out(blk),
    .function_block_out(fb), .healthy_lamp_out(hl), .alarm_lamp_out(al), .failure_contact_out(fc),
    .event_valid_out(evv), .event_code_out(evc), .event_level_out(evl));
  saa_centre_model saa_centre_model_i (.clk_in(core_clk_in), .resetn_in(resetn_in), .ev_valid_in(evv),
    .ev_code_in(evc), .ev_level_in(evl), .ev_count_out(cnt), .ev_code_out(lc), .ev_level_out(ll));
  // ****************************************************************
  // Clock and shared tasks
  // ****************************************************************
  // Free running clock at 200 MHz.
  always #2.5 core_clk_in = ~core_clk_in;
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask
  // One AHB-Lite single word transfer; read data is taken at the data phase edge.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= w;
    @(posedge core_clk_in);
    while (hrdy !== 1'b1) @(posedge core_clk_in);
    htrans <= 2'h0; hsel <= 1'b0; hwdata <= d;
    @(posedge core_clk_in);
    while (hrdy !== 1'b1) @(posedge core_clk_in);
    rd = hrd;
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(n, e, rd & m)
    `CHK("hresp", 1'b0, hresp)
  endtask
  task automatic frame(input logic [15:0] c, input logic crc, input logic q);
    @(posedge core_clk_in);
    fv <= 1'b1; fcnt <= c; fcrc <= crc; fq <= q;
    @(posedge core_clk_in);
    fv <= 1'b0;
    wt(6);
  endtask
  task automatic lamps(input logic b, input logic [4:0] f);
    `CHK("block", b, blk)
    `CHK("healthy", ~b, hl)
    `CHK("alarm_lamp", 1'b1, al)
    `CHK("contact", b, fc)
    `CHK("fn_block", f, fb)
  endtask
  task automatic setsrc(input int k, input logic v);
    @(posedge core_clk_in);
    case (k)
      0: ssel <= v ? 2'h0 : 2'h1;
      1: fovr <= v;
      2: fsl <= v;
      3: bo[0] <= v;
      default: pnc[0] <= v;
    endcase
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs();
    wt(30);
    rchk("tmo_alarm", 8'h08, 32'h20, 32'h20);
    rchk("pos_time", 8'h0c, 32'hffffffff, 32'h03e80014);
    rchk("fib_tmo", 8'h10, 32'hffffffff, 32'h0000000a);
    bus(1'b1, 8'h10, 32'h0000ffff);
    bus(1'b1, 8'h0c, 32'h00020003);
    bus(1'b1, 8'h00, 32'hffffffff);
    frame(16'h0005, 1'b1, 1'b1);
    rchk("fib_tmo_wr", 8'h10, 32'hffff, 32'hffff);
    rchk("status_idle", 8'h00, 32'h1f, 32'h08);
    rchk("unmapped", 8'h40, 32'hffffffff, 32'h0);
    $display("t_regs done");
  endtask
  task automatic t_fail();
    for (int i = 0; i < 7; i++)
    begin
      @(posedge core_clk_in);
      fpin[i] <= 1'b1;
      wt(8);
      lamps(1'b1, 5'h1f);
      rchk("fail_src", 8'h04, 32'h7f, 32'h1 << i);
      @(posedge core_clk_in);
      fpin <= 7'h00;
      wt(8);
      `CHK("fail_clear", 1'b0, blk)
    end
    @(posedge core_clk_in);
    fpin <= 7'h09;
    wt(8);
    @(posedge core_clk_in);
    fpin <= 7'h08;
    wt(8);
    `CHK("one_left", 1'b1, blk)
    rchk("fail_sum", 8'h00, 32'h1, 32'h1);
    @(posedge core_clk_in);
    fpin <= 7'h00;
    wt(8);
    $display("t_fail done");
  endtask
  task automatic t_alm();
    logic [15:0] c0;
    for (int k = 0; k < 5; k++)
    begin
      c0 = cnt;
      setsrc(k, 1'b1);
      wt(40);
      `CHK("ev_count", c0 + 16'h0001, cnt)
      lamps(1'b0, fbx[k]);
      rchk("alm_src", 8'h08, 32'h1 << bits[k], 32'h1 << bits[k]);
      `CHK("ev_code", 8'(bits[k] + 7), lc)
      `CHK("ev_level", 1'b1, ll)
      rchk("ev_reg", 8'h14, 32'h1ff, 32'h100 | (bits[k] + 7));
      setsrc(k, 1'b0);
      wt(40);
      rchk("alm_gone", 8'h08, 32'h1 << bits[k], 32'h0);
    end
    $display("t_alm done");
  endtask
  task automatic t_fib();
    frame(16'h0009, 1'b0, 1'b1);
    rchk("crc", 8'h08, 32'h58, 32'h08);
    frame(16'h0006, 1'b1, 1'b1);
    rchk("crc_ok", 8'h08, 32'h58, 32'h00);
    frame(16'h0009, 1'b1, 1'b1);
    rchk("seq", 8'h08, 32'h58, 32'h10);
    frame(16'h000a, 1'b1, 1'b0);
    rchk("quality", 8'h08, 32'h58, 32'h40);
    `CHK("fib_block", 5'h04, fb)
    frame(16'h000b, 1'b1, 1'b1);
    $display("t_fib done");
  endtask
  task automatic t_long();
    @(posedge core_clk_in);
    sup <= 1'b1; ctf <= 1'b1; vtf <= 1'b1; resv <= 16'h0200; phv <= 16'h0010;
    wt(1240);
    rchk("vt_early", 8'h08, 32'h200, 32'h0);
    wt(30);
    rchk("vt_up", 8'h08, 32'h200, 32'h200);
    wt(8700);
    rchk("long_early", 8'h08, 32'hd80, 32'h0);
    wt(40);
    rchk("long_up", 8'h08, 32'hd80, 32'hd80);
    lamps(1'b0, 5'h03);
    @(posedge core_clk_in);
    resv <= 16'h0000; phv <= 16'h1000; sup <= 1'b0; ctf <= 1'b0; vtf <= 1'b0;
    wt(980);
    rchk("drop_early", 8'h08, 32'h500, 32'h500);
    wt(40);
    rchk("drop_done", 8'h08, 32'h500, 32'h0);
    $display("t_long done");
  endtask
  task automatic t_tsync();
    @(posedge core_clk_in);
    tsf <= 1'b1;
    wt(59980);
    rchk("ts_early", 8'h08, 32'h1, 32'h0);
    wt(40);
    rchk("ts_up", 8'h08, 32'h1, 32'h1);
    @(posedge core_clk_in);
    tsf <= 1'b0;
    wt(4);
    rchk("ts_clear", 8'h08, 32'h1, 32'h0);
    $display("t_tsync done");
  endtask
  // Main sequence after four cycles of reset.
  initial
  begin
    repeat (4) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    t_regs();
    t_fail();
    t_alm();
    t_fib();
    t_long();
    t_tsync();
    test_done();
  end
  // Watchdog sized a little above the longest run of all scenarios.
  initial
  begin
    #450000;
    bad_count++;
    test_done();
  end
endmodule
`default_nettype wire
